// file: verilog/block_power_pkg.sv
// constants, field layouts and carriers for the block power controller
package block_power_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] OFS_MASK_PIN_LOW = 8'h01;
	localparam logic [7:0] OFS_MASK_PIN_HIGH = 8'h02;
	localparam logic [7:0] OFS_HALF_DUPLEX = 8'h03;
	localparam logic [7:0] OFS_STATUS = 8'h1F;

	// ****************************************
	// mask bit positions
	// ****************************************
	localparam int BIT_PLL = 7;
	localparam int BIT_TX_CONV_AMP = 6;
	localparam int BIT_TX_DIGITAL = 5;
	localparam int BIT_BIAS_REF = 4;
	localparam int BIT_ADC_CM_REF = 3;
	localparam int BIT_ADC = 2;
	localparam int BIT_GAIN_BIAS = 1;
	localparam int BIT_RX_GAIN_AMP = 0;

	// ****************************************
	// half-duplex register fields
	// ****************************************
	localparam int HD_DELAY_MSB = 7;
	localparam int HD_DELAY_LSB = 3;
	localparam int HD_RX_VIA_TRANSMIT_ENABLE_PIN = 2;
	localparam int HD_TX_FAST_EN = 1;
	localparam int HD_RX_FAST_EN = 0;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_MASK_PIN_LOW = 8'h00;
	localparam logic [7:0] RST_MASK_PIN_HIGH = 8'h7F;
	localparam logic [7:0] RST_MASK_PIN_HIGH_LOWEST = 8'hFF;
	localparam logic [7:0] RST_HALF_DUPLEX = 8'hFF;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 40000;
	localparam int TX_UP_PS = 500000;
	localparam int RX_UP_PS = 2000000;
	localparam int TX_UP_CYC = TX_UP_PS / CLK_PERIOD_PS;
	localparam int RX_UP_CYC = RX_UP_PS / CLK_PERIOD_PS;
	localparam int FLUSH_WORD_CLKS = 33;

	// burst pins from the back end
	typedef struct packed {
		logic txEnable;
		logic rxEnable;
		logic transmit_quiet_pin;
		logic txWordClk;
	} burst_pins_s;

	// effective power controls toward the analog blocks
	typedef struct packed {
		logic [7:0] blockDown;
		logic lineAmpDown;
		logic converterDown;
		logic filterDisable;
		logic filterFlush;
	} power_ctl_s;

endpackage

// file: verilog/block_power_control.sv
// power-down mask selection and half-duplex burst power control
`timescale 1ns/1ps

// How it works
// (RULE1) pin low: first mask powers blocks down
// (RULE2) pin high: second mask powers blocks down
// (RULE3) select pin acts combinationally, no clock wait
// (RULE4) mode strap low half-duplex, high full-duplex
// (RULE5) both masks share one eight-block bit layout
// (RULE6) reset: first mask all on, second all off except PLL
// (RULE7) full-duplex plus profile strap: PLL off, osc buffered
// (RULE8) controller programs complementary masks, toggles select pin
// (RULE9) burst power paths switch within stated times
// (RULE10) full-duplex quiet low: amp down, filter disabled
// (RULE11) controller flushes filter with zeros around power-down
// (RULE12) half-duplex register ignored in full-duplex
// (RULE13) select pin keeps master control in half-duplex
// (RULE14) fast control touches only line amp, digital, ADC, gain amp
// (RULE15) default: transmit enable drives, converter stays powered
// (RULE16) enable falling starts delayed transmit shutdown
// (RULE17) five-bit delay field, 0 to 31, reset 31
// (RULE18) midscale flush for 33 word clocks before shutdown; code starts flush and delay together at enable fall
// (RULE19) enable rising powers transmit up without delay
// (RULE20) bit 2 picks receive control source
// (RULE21) via transmit enable: fall powers rx up, rise down
// (RULE22) via receive enable: rise powers rx up, fall down
// (RULE23) bits 1 and 0 enable fast tx/rx down
// (RULE24) delay counts word clocks; new rise cancels shutdown
// (RULE25) effective down is mask OR fast request
module block_power_control #(
	parameter int DELAY_W = 5 // width of the shutdown delay field
)(
	input wire logic core_clk, // 25 MHz system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic modeStrap, // interface strap, high full-duplex
	input wire logic profileStrap, // reset profile strap
	input wire logic powerSelectPin, // selects which mask is applied
	input wire logic converterOutputsUsed, // converter outputs in use
	input wire block_power_pkg::burst_pins_s burstPins, // burst control pins
	input wire logic regWrite, // register write strobe
	input wire logic regRead, // register read strobe
	input wire logic [7:0] regAddr, // register offset
	input wire logic [7:0] regWrData, // register write data
	output logic [7:0] regRdData, // register read data
	output logic regRdValid, // read data valid pulse
	output block_power_pkg::power_ctl_s powerCtl, // power controls to blocks
	output logic halfDuplexMode, // captured interface mode
	output logic receiveClockBuffered, // receive clock carries osc input
	output logic txPathReady, // transmit path settled
	output logic rxPathReady // receive path settled
);

	// ****************************************
	// state
	// ****************************************
	logic [7:0] maskLow_q;
	logic [7:0] maskHigh_q;
	logic [7:0] halfDuplex_q;
	logic fullDuplex_q;
	logic profile_q;
	logic txEnPrev_q;
	logic rxEnPrev_q;
	logic wordClkPrev_q;
	logic [DELAY_W-1:0] delayCnt_q;
	logic delayActive_q;
	logic [5:0] flushCnt_q;
	logic txFastDown_q;
	logic rxFastDown_q;
	logic [5:0] txSettle_q;
	logic [5:0] rxSettle_q;
	logic txRise;
	logic txFall;
	logic rxRise;
	logic rxFall;
	logic wordTick;
	logic hdActive;
	logic [7:0] selMask;
	logic [7:0] fastMask;
	logic txBlocksUp;
	logic rxBlocksUp;

	// count a settle timer up to its bound while the path is powered
	function automatic logic [5:0] settle(input logic up, input logic [5:0] cnt,
		input logic [5:0] lim);
		if (!up)
		begin
			settle = 6'h00;
		end
		else if (cnt < lim)
		begin
			settle = cnt + 6'h01;
		end
		else
		begin
			settle = cnt;
		end
	endfunction

	// ****************************************
	// edge detection on synchronous pins
	// ****************************************

	// previous pin levels
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			txEnPrev_q <= 1'b0;
			rxEnPrev_q <= 1'b0;
			wordClkPrev_q <= 1'b0;
		end
		else
		begin
			txEnPrev_q <= burstPins.txEnable;
			rxEnPrev_q <= burstPins.rxEnable;
			wordClkPrev_q <= burstPins.txWordClk;
		end
	end

	// edge pulses
	assign txRise = burstPins.txEnable & ~txEnPrev_q;
	assign txFall = ~burstPins.txEnable & txEnPrev_q;
	assign rxRise = burstPins.rxEnable & ~rxEnPrev_q;
	assign rxFall = ~burstPins.rxEnable & rxEnPrev_q;
	assign wordTick = burstPins.txWordClk & ~wordClkPrev_q; // [RULE24]

	// ****************************************
	// straps and registers
	// ****************************************

	// straps caught while reset is held
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			fullDuplex_q <= modeStrap; // [RULE4]
			profile_q <= profileStrap;
		end
	end

	// mask registers, second mask default depends on straps
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			maskLow_q <= block_power_pkg::RST_MASK_PIN_LOW; // [RULE6]
			if (modeStrap && profileStrap)
			begin
				maskHigh_q <= block_power_pkg::RST_MASK_PIN_HIGH_LOWEST; // [RULE7]
			end
			else
			begin
				maskHigh_q <= block_power_pkg::RST_MASK_PIN_HIGH; // [RULE6]
			end
		end
		else if (regWrite)
		begin
			if (regAddr == block_power_pkg::OFS_MASK_PIN_LOW)
			begin
				maskLow_q <= regWrData; // [RULE5]
			end
			if (regAddr == block_power_pkg::OFS_MASK_PIN_HIGH)
			begin
				maskHigh_q <= regWrData; // [RULE5]
			end
		end
	end

	// half-duplex power savings register
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			halfDuplex_q <= block_power_pkg::RST_HALF_DUPLEX; // [RULE17]
		end
		else if (regWrite && regAddr == block_power_pkg::OFS_HALF_DUPLEX)
		begin
			halfDuplex_q <= regWrData;
		end
	end

	// read port, one-cycle answer
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			regRdData <= 8'h00;
			regRdValid <= 1'b0;
		end
		else
		begin
			regRdValid <= regRead;
			if (regRead)
			begin
				case (regAddr)
					block_power_pkg::OFS_MASK_PIN_LOW: regRdData <= maskLow_q;
					block_power_pkg::OFS_MASK_PIN_HIGH: regRdData <= maskHigh_q;
					block_power_pkg::OFS_HALF_DUPLEX: regRdData <= halfDuplex_q;
					block_power_pkg::OFS_STATUS: regRdData <= {2'b00, fullDuplex_q,
						txFastDown_q, rxFastDown_q, delayActive_q, txPathReady,
						rxPathReady};
					default: regRdData <= 8'h00;
				endcase
			end
		end
	end

	// ****************************************
	// half-duplex fast transmit control
	// ****************************************
	assign hdActive = ~fullDuplex_q; // [RULE12]

	// delayed shutdown counter
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			delayActive_q <= 1'b0;
			delayCnt_q <= '0;
		end
		else if (txRise || !hdActive)
		begin
			delayActive_q <= 1'b0; // [RULE24]
		end
		else if (txFall)
		begin
			delayActive_q <= 1'b1; // [RULE16]
			delayCnt_q <= halfDuplex_q[block_power_pkg::HD_DELAY_MSB:
				block_power_pkg::HD_DELAY_LSB]; // [RULE17]
		end
		else if (delayActive_q && delayCnt_q == '0)
		begin
			delayActive_q <= 1'b0;
		end
		else if (delayActive_q && wordTick)
		begin
			delayCnt_q <= delayCnt_q - 1'b1; // [RULE24]
		end
	end

	// midscale flush window after enable falls
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			flushCnt_q <= 6'h00;
		end
		else if (txRise || !hdActive)
		begin
			flushCnt_q <= 6'h00;
		end
		else if (txFall)
		begin
			flushCnt_q <= 6'(block_power_pkg::FLUSH_WORD_CLKS); // [RULE18]
		end
		else if (flushCnt_q != 6'h00 && wordTick)
		begin
			flushCnt_q <= flushCnt_q - 6'h01;
		end
	end

	// transmit fast power-down request
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			txFastDown_q <= 1'b0;
		end
		else if (!hdActive || !halfDuplex_q[block_power_pkg::HD_TX_FAST_EN])
		begin
			txFastDown_q <= 1'b0; // [RULE23]
		end
		else if (txRise)
		begin
			txFastDown_q <= 1'b0; // [RULE19]
		end
		else if (delayActive_q && delayCnt_q == '0)
		begin
			txFastDown_q <= 1'b1; // [RULE16]
		end
	end

	// ****************************************
	// half-duplex fast receive control
	// ****************************************

	// receive fast power-down request from selected source
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rxFastDown_q <= 1'b0;
		end
		else if (!hdActive || !halfDuplex_q[block_power_pkg::HD_RX_FAST_EN])
		begin
			rxFastDown_q <= 1'b0; // [RULE23]
		end
		else if (halfDuplex_q[block_power_pkg::HD_RX_VIA_TRANSMIT_ENABLE_PIN]) // [RULE20]
		begin
			if (txRise)
			begin
				rxFastDown_q <= 1'b1; // [RULE21]
			end
			else if (txFall)
			begin
				rxFastDown_q <= 1'b0; // [RULE21]
			end
		end
		else if (rxFall)
		begin
			rxFastDown_q <= 1'b1; // [RULE22]
		end
		else if (rxRise)
		begin
			rxFastDown_q <= 1'b0; // [RULE22]
		end
	end

	// ****************************************
	// effective power controls
	// ****************************************

	// pin-selected mask, no clock in the path
	assign selMask = powerSelectPin ? maskHigh_q : maskLow_q; // [RULE1] [RULE2] [RULE3] [RULE13]

	// fast requests reach only the four fast blocks
	always_comb
	begin
		fastMask = 8'h00;
		fastMask[block_power_pkg::BIT_TX_DIGITAL] = txFastDown_q; // [RULE14]
		fastMask[block_power_pkg::BIT_ADC] = rxFastDown_q; // [RULE14]
		fastMask[block_power_pkg::BIT_RX_GAIN_AMP] = rxFastDown_q; // [RULE14]
	end

	// block outputs combine mask, fast and quiet controls
	always_comb
	begin
		powerCtl.blockDown = selMask | fastMask; // [RULE25]
		powerCtl.lineAmpDown = selMask[block_power_pkg::BIT_TX_CONV_AMP] |
			txFastDown_q; // [RULE15]
		powerCtl.converterDown = selMask[block_power_pkg::BIT_TX_CONV_AMP];
		powerCtl.filterDisable = 1'b0;
		powerCtl.filterFlush = (flushCnt_q != 6'h00); // [RULE18]
		if (fullDuplex_q && !burstPins.transmit_quiet_pin)
		begin
			powerCtl.lineAmpDown = 1'b1; // [RULE10]
			powerCtl.filterDisable = 1'b1; // [RULE10]
			powerCtl.converterDown = selMask[block_power_pkg::BIT_TX_CONV_AMP] |
				~converterOutputsUsed; // [RULE10]
		end
	end

	// ****************************************
	// mode and settle status
	// ****************************************
	assign halfDuplexMode = hdActive;
	assign receiveClockBuffered = fullDuplex_q & profile_q; // [RULE7]
	assign txBlocksUp = ~powerCtl.blockDown[block_power_pkg::BIT_TX_DIGITAL] &
		~powerCtl.lineAmpDown;
	assign rxBlocksUp = ~powerCtl.blockDown[block_power_pkg::BIT_ADC] &
		~powerCtl.blockDown[block_power_pkg::BIT_RX_GAIN_AMP];

	// settle timers for burst power-up windows
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			txSettle_q <= 6'h00;
			rxSettle_q <= 6'h00;
		end
		else
		begin
			txSettle_q <= settle(txBlocksUp, txSettle_q,
				6'(block_power_pkg::TX_UP_CYC)); // [RULE9]
			rxSettle_q <= settle(rxBlocksUp, rxSettle_q,
				6'(block_power_pkg::RX_UP_CYC)); // [RULE9]
		end
	end

	// ready flags once the settle window has passed
	assign txPathReady = (txSettle_q == 6'(block_power_pkg::TX_UP_CYC));
	assign rxPathReady = (rxSettle_q == 6'(block_power_pkg::RX_UP_CYC));

endmodule

// file: bench/block_power_control_properties.sv
// port checker for the block power controller
`timescale 1ns/1ps
module block_power_control_properties (
	input wire logic core_clk, // clock
	input wire logic rst, // reset
	input wire logic modeStrap, // mode strap
	input wire logic profileStrap, // profile strap
	input wire logic powerSelectPin, // mask select
	input wire block_power_pkg::burst_pins_s burstPins, // burst pins
	input wire logic regWrite, // write strobe
	input wire logic regRead, // read strobe
	input wire logic [7:0] regAddr, // offset
	input wire logic [7:0] regWrData, // write data
	input wire logic regRdValid, // read valid
	input wire block_power_pkg::power_ctl_s powerCtl, // power controls
	input wire logic halfDuplexMode // captured mode
);
	// ****
	// shadow registers
	// ****
	logic [7:0] maskLow_q, maskHigh_q, hd_q, sel;
	assign sel = powerSelectPin ? maskHigh_q : maskLow_q;
	// follow writes to the three power registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			maskLow_q <= 8'h00;
			maskHigh_q <= (modeStrap & profileStrap) ? 8'hFF : 8'h7F;
			hd_q <= 8'hFF;
		end
		else if (regWrite)
		begin
			if (regAddr == block_power_pkg::OFS_MASK_PIN_LOW)
				maskLow_q <= regWrData;
			if (regAddr == block_power_pkg::OFS_MASK_PIN_HIGH)
				maskHigh_q <= regWrData;
			if (regAddr == block_power_pkg::OFS_HALF_DUPLEX)
				hd_q <= regWrData;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_RD_VALID: assert property (regRead |=> regRdValid)
		else $error("read not answered");
	AST_RD_SOURCE: assert property (regRdValid |-> $past(regRead))
		else $error("read valid without read");
	AST_MASK_COVER: assert property ((powerCtl.blockDown & sel) == sel)
		else $error("selected mask bit not powered down");
	AST_FD_MASK: assert property (!halfDuplexMode |-> powerCtl.blockDown == sel)
		else $error("full duplex power differs from mask");
	AST_FD_QUIET: assert property (!halfDuplexMode && !burstPins.transmit_quiet_pin |-> powerCtl.lineAmpDown && powerCtl.filterDisable)
		else $error("quiet pin did not shut amp");
	AST_TX_RISE: assert property (halfDuplexMode && $rose(burstPins.txEnable) && !sel[5] |-> ##[1:3] !powerCtl.blockDown[5])
		else $error("transmit not powered up");
	AST_RX_DOWN: assert property (halfDuplexMode && hd_q[2] && hd_q[0] && $rose(burstPins.txEnable) |-> ##[1:3] powerCtl.blockDown[0] && powerCtl.blockDown[2])
		else $error("receive not powered down");
	AST_RX_UP: assert property (halfDuplexMode && hd_q[2] && !sel[0] && $fell(burstPins.txEnable) |-> ##[1:3] !powerCtl.blockDown[0])
		else $error("receive not powered up");
	AST_RX_PIN: assert property (halfDuplexMode && !hd_q[2] && hd_q[0] && $fell(burstPins.rxEnable) |-> ##[1:3] powerCtl.blockDown[0])
		else $error("receive pin fall ignored");
endmodule

bind block_power_control block_power_control_properties block_power_control_properties_i (
	.core_clk, .rst, .modeStrap, .profileStrap, .powerSelectPin, .burstPins, .regWrite,
	.regRead, .regAddr, .regWrData, .regRdValid, .powerCtl, .halfDuplexMode);

// file: bench/burst_partner.sv
// back-end model driving the burst pins
`timescale 1ns/1ps
module burst_partner (
	input wire logic core_clk, // clock
	input wire logic transmit_enable_pin, // transmit burst request
	input wire logic receive_enable_pin, // receive burst request
	input wire logic quietReq, // quiet request
	input wire logic tickRun, // word clock running
	output block_power_pkg::burst_pins_s pins // burst pins
);
	// ****
	// pin drive
	// ****
	logic [1:0] div = 2'h0;
	initial pins = '0;
	// quarter-rate word clock, held low when stopped; pins move just after the rising edge
	always @(posedge core_clk)
	begin
		div <= tickRun ? div + 2'h1 : 2'h0;
		pins.txWordClk <= tickRun & div[1];
		pins.txEnable <= transmit_enable_pin;
		pins.rxEnable <= receive_enable_pin;
		pins.transmit_quiet_pin <= !quietReq;
	end
endmodule

// file: bench/block_power_control_tb.sv
// self-checking bench for the block power controller
`timescale 1ns/1ps
module block_power_control_tb;
	logic core_clk = 0, rst = 1, modeStrap = 0, profileStrap = 0, powerSelectPin = 0;
	logic regWrite = 0, regRead = 0, transmit_enable_pin = 0, receive_enable_pin = 0, quiet = 0, tickRun = 0, convUsed = 1;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, mLow, mHigh;
	logic regRdValid, halfDuplexMode, rcb;
	block_power_pkg::burst_pins_s pins;
	block_power_pkg::power_ctl_s powerCtl;
	logic [7:0] expQ[$];
	int fail_count = 0, comparisons = 0, seed = 2532, cycles = 0, i;
	initial forever #20 core_clk = ~core_clk;
	burst_partner burst_partner_i (.core_clk, .transmit_enable_pin, .receive_enable_pin, .quietReq(quiet), .tickRun, .pins);
	block_power_control block_power_control_i (.core_clk, .rst, .modeStrap, .profileStrap,
		.powerSelectPin, .converterOutputsUsed(convUsed), .burstPins(pins), .regWrite, .regRead,
		.regAddr, .regWrData, .regRdData, .regRdValid, .powerCtl, .halfDuplexMode,
		.receiveClockBuffered(rcb), .txPathReady(), .rxPathReady());
	// ****
	// tasks
	// ****
	task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wt(1);
		regWrite = 1;
		regAddr = a;
		regWrData = d;
		wt(1);
		regWrite = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		wt(1);
		regRead = 1;
		regAddr = a;
		expQ.push_back(e);
		wt(1);
		regRead = 0;
	endtask
	task automatic summarize();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// read answers against the oldest expectation, looked at mid-cycle
	always @(negedge core_clk)
		if (regRdValid === 1'b1)
			check("read data", expQ.size() > 0 ? expQ.pop_front() : 8'hXX, regRdData);
	// hang guard
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles > 5000)
		begin
			fail_count++;
			summarize();
		end
	end
	// ****
	// scenarios
	// ****
	initial
	begin
		wt(5);
		rst = 0;
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h7F);
		rd(8'h03, 8'hFF);
		rd(8'h10, 8'h00);
		check("halfDuplexMode", 8'(halfDuplexMode), 8'h01);
		for (i = 0; i < 6; i++)
		begin
			mLow = $random(seed);
			mHigh = $random(seed);
			wr(8'h01, mLow);
			wr(8'h02, mHigh);
			rd(8'h01, mLow);
			powerSelectPin = 0;
			#1 check("blockDown", mLow, powerCtl.blockDown);
			powerSelectPin = 1;
			#1 check("blockDown", mHigh, powerCtl.blockDown);
		end
		wr(8'h02, 8'h00);
		wr(8'h03, 8'h17);
		transmit_enable_pin = 1;
		wt(4);
		check("blockDown", 8'h05, powerCtl.blockDown);
		transmit_enable_pin = 0;
		tickRun = 1;
		wt(4);
		check("blockDown", 8'h00, powerCtl.blockDown);
		check("filterFlush", 8'(powerCtl.filterFlush), 8'h01);
		wt(20);
		check("blockDown", 8'h20, powerCtl.blockDown);
		check("lineAmpDown", 8'(powerCtl.lineAmpDown), 8'h01);
		check("converterDown", 8'(powerCtl.converterDown), 8'h00);
		wt(140);
		check("filterFlush", 8'(powerCtl.filterFlush), 8'h00);
		transmit_enable_pin = 1;
		wt(4);
		check("blockDown", 8'h05, powerCtl.blockDown);
		transmit_enable_pin = 0;
		wt(3);
		transmit_enable_pin = 1;
		wt(30);
		check("lineAmpDown", 8'(powerCtl.lineAmpDown), 8'h00);
		tickRun = 0;
		wr(8'h03, 8'h13);
		receive_enable_pin = 1;
		wt(4);
		check("rxDown", 8'h00, powerCtl.blockDown & 8'h05);
		receive_enable_pin = 0;
		wt(4);
		check("rxDown", 8'h05, powerCtl.blockDown & 8'h05);
		wr(8'h03, 8'h10);
		transmit_enable_pin = 0;
		wt(40);
		check("blockDown", 8'h00, powerCtl.blockDown);
		rst = 1;
		modeStrap = 1;
		profileStrap = 1;
		wt(5);
		rst = 0;
		rd(8'h02, 8'hFF);
		check("receiveClockBuffered", 8'(rcb), 8'h01);
		wr(8'h01, 8'h60);
		wr(8'h02, 8'h05);
		transmit_enable_pin = 1;
		wt(4);
		check("blockDown", 8'h05, powerCtl.blockDown);
		powerSelectPin = 0;
		#1 check("blockDown", 8'h60, powerCtl.blockDown);
		quiet = 1;
		wt(2);
		check("lineAmpDown", 8'(powerCtl.lineAmpDown), 8'h01);
		check("converterDown", 8'(powerCtl.converterDown), 8'h01);
		check("filterDisable", 8'h01, 8'(powerCtl.filterDisable));
		powerSelectPin = 1;
		#1 check("converterDown", 8'h00, 8'(powerCtl.converterDown));
		convUsed = 0;
		#1 check("converterDown", 8'h01, 8'(powerCtl.converterDown));
		powerSelectPin = 0;
		wt(60);
		rd(8'h1F, 8'h21);
		wt(3);
		summarize();
	end
endmodule
